// [rtl/sr_pkg.sv]
// Shared constants, state encoding and threshold lookup for the sleep logic
package sr_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BURST_IDLE_US = 20;
	localparam int BURST_IDLE_CYC = BURST_IDLE_US * CLK_MHZ;
	localparam int SLEEP_CONFIRM_CYC = 512;
	localparam int BLANK_SW = 8;
	localparam int BLANK_CYC = 2 * BLANK_SW;
	localparam int RESTART_SW = 12;
	localparam int RESTART_CYC = 2 * RESTART_SW;
	localparam int PCT_FULL = 100;
	localparam int EXIT_ACC_LIMIT = 100;
	localparam logic [6:0] TON_INIT_PCT = 7'h1E;
	localparam logic [6:0] TOFF_INIT_PCT = 7'h32;
	localparam logic [6:0] SOFT_STEP_PCT = 7'h05;
	localparam logic [6:0] SOFT_FLOOR_PCT = 7'h14;
	localparam logic [6:0] DOFF_100K_PCT = 7'h28;
	localparam logic [6:0] DOFF_180K_PCT = 7'h19;
	localparam logic [1:0] EN_CODE_100K = 2'h0;
	localparam logic [1:0] EN_CODE_180K = 2'h1;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] DUTY_OFF = 8'h08;
	localparam int CTRL_INHIBIT_BIT = 0;
	localparam int CTRL_TON_LSB = 8;
	localparam int CTRL_TOFF_LSB = 16;
	localparam logic [6:0] TON_TARGET_RST = 7'h0A;
	localparam logic [6:0] TOFF_TARGET_RST = 7'h5F;

	typedef enum logic [2:0] {
		ST_STARTUP = 3'h0,
		ST_RUN = 3'h1,
		ST_SOFT = 3'h2,
		ST_SLEEP = 3'h3,
		ST_BURST = 3'h4,
		ST_RESTART = 3'h5,
		ST_OFF = 3'h6
	} state_t;

	// Exit duty by enable class and program class; open enable uses row I
	function automatic logic [6:0] exit_duty(input logic [1:0] en_code,
		input logic [1:0] exit_level_program_pin_code);
		logic [6:0] d;
		d = 7'h00;
		if (en_code == EN_CODE_180K) begin
			unique case (exit_level_program_pin_code)
				2'h0: d = 7'h4B;
				2'h1: d = 7'h46;
				2'h2: d = 7'h3C;
				default: d = 7'h37;
			endcase
		end else begin
			unique case (exit_level_program_pin_code)
				2'h0: d = 7'h50;
				2'h1: d = 7'h4B;
				2'h2: d = 7'h41;
				default: d = 7'h3C;
			endcase
		end
		return d;
	endfunction
endpackage

// [rtl/sr_duty_meter.sv]
// Half-period and conduction timer with serial duty-percent divider
`timescale 1ns/100ps
`default_nettype none
module sr_duty_meter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pulse,
	input wire logic cond,
	input wire logic gate,
	input wire logic driving,
	output logic [15:0] period_q,
	output logic [6:0] duty_q,
	output logic duty_valid_q
);
	logic pulse_prev_q, cond_prev_q, gate_prev_q;
	logic per_run_q, cond_run_q;
	logic [15:0] per_cnt_q, cond_cnt_q;
	logic div_busy_q;
	logic [2:0] bit_q;
	logic [22:0] rem_q;
	logic [15:0] div_per_q;
	logic [6:0] quo_q;
	logic pulse_rise, pulse_fall, cond_start, cond_end;
	logic [22:0] trial;
	logic [6:0] quo_next;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	assign pulse_rise = pulse && !pulse_prev_q;
	assign pulse_fall = !pulse && pulse_prev_q;
	assign cond_start = cond && !cond_prev_q;
	// Gate off ends conduction when driving, diode end in sleep
	assign cond_end = driving ? (!gate && gate_prev_q)
		: (!cond && cond_prev_q);
	assign trial = 23'({7'h00, div_per_q} << bit_q);
	assign quo_next = quo_q | 7'(7'h01 << bit_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_prev_q <= 1'b0;
			cond_prev_q <= 1'b0;
			gate_prev_q <= 1'b0;
		end else begin
			pulse_prev_q <= pulse;
			cond_prev_q <= cond;
			gate_prev_q <= gate;
		end
	end

	// Period runs from a pulse's fall to the next pulse's rise
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_run_q <= 1'b0;
			per_cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (pulse_fall) begin
			per_run_q <= 1'b1;
			// Fall cycle itself belongs to the period
			per_cnt_q <= 16'h0001;
		end else if (pulse_rise && per_run_q) begin
			per_run_q <= 1'b0;
			period_q <= per_cnt_q;
		end else if (per_run_q) begin
			per_cnt_q <= sat_inc(per_cnt_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_run_q <= 1'b0;
			cond_cnt_q <= 16'h0000;
		end else if (pulse_fall) begin
			// Conduction may start on the very cycle the pulse falls
			cond_run_q <= (cond_run_q || cond_start) && !cond_end;
			cond_cnt_q <= {15'h0000, cond_start || (cond_run_q && !cond_end)};
		end else if (cond_start) begin
			cond_run_q <= 1'b1;
			if (per_run_q) cond_cnt_q <= sat_inc(cond_cnt_q);
		end else if (cond_end) begin
			cond_run_q <= 1'b0;
		end else if (cond_run_q && per_run_q) begin
			cond_cnt_q <= sat_inc(cond_cnt_q);
		end
	end

	// Restoring divide over seven cycles; periods are far longer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_busy_q <= 1'b0;
			bit_q <= 3'h0;
			rem_q <= 23'h000000;
			div_per_q <= 16'h0000;
			quo_q <= 7'h00;
			duty_q <= 7'h00;
			duty_valid_q <= 1'b0;
		end else begin
			duty_valid_q <= 1'b0;
			if (pulse_rise && per_run_q) begin
				div_busy_q <= 1'b1;
				bit_q <= 3'h6;
				rem_q <= 23'(cond_cnt_q) * 23'(sr_pkg::PCT_FULL);
				div_per_q <= per_cnt_q;
				quo_q <= 7'h00;
			end else if (div_busy_q) begin
				if (div_per_q != 16'h0000 && rem_q >= trial) begin
					rem_q <= rem_q - trial;
					quo_q <= quo_next;
				end
				if (bit_q == 3'h0) begin
					div_busy_q <= 1'b0;
					duty_valid_q <= 1'b1;
					if (div_per_q != 16'h0000 && rem_q >= trial) begin
						duty_q <= (quo_next > 7'(sr_pkg::PCT_FULL))
							? 7'(sr_pkg::PCT_FULL) : quo_next;
					end else begin
						duty_q <= (quo_q > 7'(sr_pkg::PCT_FULL))
							? 7'(sr_pkg::PCT_FULL) : quo_q;
					end
				end else begin
					bit_q <= bit_q - 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/sr_sleep_burst_controller.sv]
// Light-load sleep, burst detection and pin configuration for the SR driver
`timescale 1ns/100ps
`default_nettype none
module sr_sleep_burst_controller (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic half_period_clk,
	input wire logic cond_a,
	input wire logic cond_b,
	input wire logic arm_a,
	input wire logic arm_b,
	input wire logic gate_on_a,
	input wire logic gate_on_b,
	input wire logic supply_ok,
	input wire logic en_below_off,
	input wire logic en_above_on,
	input wire logic [1:0] en_level_code,
	input wire logic [1:0] exit_level_program_pin,
	output logic gate_drive_allow,
	output logic low_power,
	output logic en_source_run,
	output logic program_pin_source_current,
	output logic [6:0] ton_mask_pct,
	output logic [6:0] toff_point_pct
);
	sr_pkg::state_t state_q, state_d;
	logic [13:0] sync1_q, sync2_q;
	logic pulse_s, cond_s, gate_s, both_arm_s, supply_s, en_off_s, en_on_s;
	logic [1:0] en_code_s, exit_level_program_pin_code_s, en_cfg_q, exit_level_program_pin_cfg_q;
	logic [15:0] period;
	logic [6:0] duty, doff, don, soft_next, ton_target_q, toff_target_q;
	logic duty_valid, auto_en, inhibit_q, idle_hit, low_hit, exit_hit;
	logic [8:0] low_cnt_q, acc_sum;
	logic [7:0] acc_q;
	logic [4:0] blank_cnt_q, restart_cnt_q;
	logic [11:0] idle_cnt_q;
	logic blank_done, wr_pend_q;
	logic [7:0] wr_addr_q, rd_addr;
	logic [31:0] rd_mux;

	function automatic logic [6:0] step_toward(input logic [6:0] cur,
		input logic [6:0] tgt);
		if (cur < tgt) return cur + 7'h01;
		if (cur > tgt) return cur - 7'h01;
		return cur;
	endfunction

	// Pins are asynchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 14'h0000;
			sync2_q <= 14'h0000;
		end else begin
			sync1_q <= {exit_level_program_pin, en_level_code, en_above_on,
				en_below_off, supply_ok, gate_on_b, gate_on_a, arm_b, arm_a,
				cond_b, cond_a, half_period_clk};
			sync2_q <= sync1_q;
		end
	end
	assign pulse_s = sync2_q[0];
	assign cond_s = sync2_q[1] || sync2_q[2];
	assign both_arm_s = sync2_q[3] && sync2_q[4];
	assign gate_s = sync2_q[5] || sync2_q[6];
	assign supply_s = sync2_q[7];
	assign en_off_s = sync2_q[8];
	assign en_on_s = sync2_q[9];
	assign en_code_s = sync2_q[11:10];
	assign exit_level_program_pin_code_s = sync2_q[13:12];

	sr_duty_meter sr_duty_meter_inst (
		.clk(hclk),
		.rst_n(hresetn),
		.pulse(pulse_s),
		.cond(cond_s),
		.gate(gate_s),
		.driving(gate_drive_allow),
		.period_q(period),
		.duty_q(duty),
		.duty_valid_q(duty_valid)
	);

	// Configuration latched once per supply turn-on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_cfg_q <= 2'h2;
			exit_level_program_pin_cfg_q <= 2'h3;
		end else if (state_q == sr_pkg::ST_STARTUP && supply_s) begin
			en_cfg_q <= en_code_s;
			exit_level_program_pin_cfg_q <= exit_level_program_pin_code_s;
		end
	end
	assign auto_en = !en_cfg_q[1] && !inhibit_q;
	assign doff = (en_cfg_q == sr_pkg::EN_CODE_180K) ? sr_pkg::DOFF_180K_PCT
		: sr_pkg::DOFF_100K_PCT;
	assign don = sr_pkg::exit_duty(en_cfg_q, exit_level_program_pin_cfg_q);

	assign idle_hit = both_arm_s
		&& idle_cnt_q == 12'(sr_pkg::BURST_IDLE_CYC - 1);
	assign low_hit = duty_valid && duty < doff
		&& low_cnt_q == 9'(sr_pkg::SLEEP_CONFIRM_CYC - 1);
	assign acc_sum = {1'b0, acc_q} + {2'h0, duty - don};
	// Larger excess fills the accumulator in fewer cycles
	assign exit_hit = duty_valid && duty > don
		&& acc_sum >= 9'(sr_pkg::EXIT_ACC_LIMIT);
	assign blank_done = blank_cnt_q == 5'(sr_pkg::BLANK_CYC);
	assign soft_next = (toff_point_pct > sr_pkg::SOFT_STEP_PCT)
		? toff_point_pct - sr_pkg::SOFT_STEP_PCT : 7'h00;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sr_pkg::ST_STARTUP: state_d = sr_pkg::ST_RUN;
			sr_pkg::ST_RUN: begin
				if (idle_hit) state_d = sr_pkg::ST_BURST;
				else if (auto_en && low_hit) state_d = sr_pkg::ST_SOFT;
			end
			sr_pkg::ST_SOFT: begin
				if (idle_hit) state_d = sr_pkg::ST_BURST;
				else if (duty_valid && soft_next <= sr_pkg::SOFT_FLOOR_PCT)
					state_d = sr_pkg::ST_SLEEP;
			end
			sr_pkg::ST_SLEEP: begin
				if (idle_hit) state_d = sr_pkg::ST_BURST;
				else if (blank_done && exit_hit)
					state_d = sr_pkg::ST_RUN;
			end
			sr_pkg::ST_BURST: begin
				if (exit_hit) state_d = sr_pkg::ST_RESTART;
			end
			sr_pkg::ST_RESTART: begin
				if (duty_valid
					&& restart_cnt_q == 5'(sr_pkg::RESTART_CYC - 1))
					state_d = sr_pkg::ST_RUN;
			end
			sr_pkg::ST_OFF: begin
				if (en_on_s) state_d = sr_pkg::ST_BURST;
			end
			default: state_d = sr_pkg::ST_STARTUP;
		endcase
		if (state_q != sr_pkg::ST_STARTUP && state_q != sr_pkg::ST_OFF
			&& en_off_s)
			state_d = sr_pkg::ST_OFF;
		if (!supply_s) state_d = sr_pkg::ST_STARTUP;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) state_q <= sr_pkg::ST_STARTUP;
		else state_q <= state_d;
	end

	// Pin-facing outputs follow the next state so they align with state_q
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_drive_allow <= 1'b0;
			low_power <= 1'b0;
			en_source_run <= 1'b0;
			program_pin_source_current <= 1'b1;
		end else begin
			gate_drive_allow <= state_d == sr_pkg::ST_RUN
				|| state_d == sr_pkg::ST_SOFT;
			low_power <= state_d == sr_pkg::ST_SLEEP
				|| state_d == sr_pkg::ST_BURST
				|| state_d == sr_pkg::ST_OFF;
			en_source_run <= state_d != sr_pkg::ST_STARTUP;
			program_pin_source_current <=
				state_d == sr_pkg::ST_STARTUP;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt_q <= 9'h000;
		end else if (state_q != sr_pkg::ST_RUN || (duty_valid && duty >= doff)) begin
			low_cnt_q <= 9'h000;
		end else if (duty_valid
			&& low_cnt_q != 9'(sr_pkg::SLEEP_CONFIRM_CYC - 1)) begin
			low_cnt_q <= low_cnt_q + 9'h001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt_q <= 12'h000;
		end else if (!both_arm_s || state_q == sr_pkg::ST_BURST
			|| state_q == sr_pkg::ST_RESTART) begin
			idle_cnt_q <= 12'h000;
		end else if (idle_cnt_q != 12'(sr_pkg::BURST_IDLE_CYC - 1)) begin
			idle_cnt_q <= idle_cnt_q + 12'h001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blank_cnt_q <= 5'h00;
		end else if (state_q != sr_pkg::ST_SLEEP) begin
			blank_cnt_q <= 5'h00;
		end else if (duty_valid && !blank_done) begin
			blank_cnt_q <= blank_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			restart_cnt_q <= 5'h00;
		end else if (state_q != sr_pkg::ST_RESTART) begin
			restart_cnt_q <= 5'h00;
		end else if (duty_valid) begin
			restart_cnt_q <= restart_cnt_q + 5'h01;
		end
	end

	// Excess accumulates only while a wake check is live
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= 8'h00;
		end else if (!(state_q == sr_pkg::ST_BURST
			|| (state_q == sr_pkg::ST_SLEEP && blank_done))) begin
			acc_q <= 8'h00;
		end else if (duty_valid) begin
			acc_q <= (duty > don) ? acc_sum[7:0] : 8'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ton_mask_pct <= sr_pkg::TON_INIT_PCT;
			toff_point_pct <= sr_pkg::TOFF_INIT_PCT;
		end else if (state_d == sr_pkg::ST_RUN && state_q != sr_pkg::ST_RUN
			&& state_q != sr_pkg::ST_SOFT) begin
			ton_mask_pct <= sr_pkg::TON_INIT_PCT;
			toff_point_pct <= sr_pkg::TOFF_INIT_PCT;
		end else if (state_q == sr_pkg::ST_RUN && duty_valid) begin
			ton_mask_pct <= step_toward(ton_mask_pct, ton_target_q);
			toff_point_pct <= step_toward(toff_point_pct,
				toff_target_q);
		end else if (state_q == sr_pkg::ST_SOFT && duty_valid) begin
			toff_point_pct <= soft_next;
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rd_addr = haddr[7:0];
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (rd_addr)
			sr_pkg::CTRL_OFF: begin
				rd_mux[sr_pkg::CTRL_INHIBIT_BIT] = inhibit_q;
				rd_mux[sr_pkg::CTRL_TON_LSB +: 7] = ton_target_q;
				rd_mux[sr_pkg::CTRL_TOFF_LSB +: 7] = toff_target_q;
			end
			sr_pkg::STATUS_OFF: rd_mux = {9'h000, don, 6'h00, exit_level_program_pin_cfg_q,
				en_cfg_q, gate_drive_allow, low_power, auto_en, state_q};
			sr_pkg::DUTY_OFF: rd_mux = {period, 9'h000, duty};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
			wr_addr_q <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h000000)
				hrdata <= rd_mux;
			else
				hrdata <= 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inhibit_q <= 1'b0;
			ton_target_q <= sr_pkg::TON_TARGET_RST;
			toff_target_q <= sr_pkg::TOFF_TARGET_RST;
		end else if (wr_pend_q && wr_addr_q == sr_pkg::CTRL_OFF) begin
			inhibit_q <= hwdata[sr_pkg::CTRL_INHIBIT_BIT];
			ton_target_q <= hwdata[sr_pkg::CTRL_TON_LSB +: 7];
			toff_target_q <= hwdata[sr_pkg::CTRL_TOFF_LSB +: 7];
		end
	end

	a_sleep_confirm: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_RUN && state_d == sr_pkg::ST_SOFT)
		|-> (low_cnt_q == 9'h1FF && duty < doff))
		else $error("sleep entered before 512 low cycles");
	a_soft_step: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_SOFT && duty_valid && state_d == state_q)
		|=> toff_point_pct < $past(toff_point_pct))
		else $error("soft transition did not lower conduction");
	a_sleep_blank: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_SLEEP && blank_cnt_q != 5'h10 && supply_s
		&& !en_off_s && !idle_hit) |=> state_q == sr_pkg::ST_SLEEP)
		else $error("sleep left during blanking");
	a_gates_off_low: assert property (@(posedge hclk) disable iff (!hresetn)
		low_power |-> !gate_drive_allow)
		else $error("gates allowed in low power");
	a_burst_time: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q != sr_pkg::ST_BURST && state_d == sr_pkg::ST_BURST
		&& state_q != sr_pkg::ST_OFF) |-> $past(both_arm_s, 8)
		&& idle_cnt_q == 12'h7CF)
		else $error("burst declared without 20 us idle");
	a_restart_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_RESTART && state_d == sr_pkg::ST_RUN)
		|-> restart_cnt_q == 5'h17
		##1 gate_drive_allow)
		else $error("gates restarted before 24 cycles");
	a_wake_init: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_SLEEP && state_d == sr_pkg::ST_RUN)
		|=> ton_mask_pct == 7'h1E && toff_point_pct == 7'h32)
		else $error("wake values not loaded");
	a_cfg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q != sr_pkg::ST_STARTUP) ##1 (state_q != sr_pkg::ST_STARTUP)
		|-> $stable(en_cfg_q) && $stable(exit_level_program_pin_cfg_q))
		else $error("configuration changed while supplied");
	a_exit_level_program_pin_src: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_q == sr_pkg::ST_STARTUP) != (!program_pin_source_current
		&& en_source_run))
		else $error("pin sources wrong for state");
	a_en_off: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_off_s && supply_s && state_q != sr_pkg::ST_STARTUP)
		|=> low_power && !gate_drive_allow)
		else $error("enable off did not stop driving");
	c_sleep: cover property (@(posedge hclk) disable iff (!hresetn)
		state_q == sr_pkg::ST_SOFT ##1 state_q == sr_pkg::ST_SLEEP);
	c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
		state_q == sr_pkg::ST_SLEEP ##1 state_q == sr_pkg::ST_RUN);
	c_burst: cover property (@(posedge hclk) disable iff (!hresetn)
		state_q == sr_pkg::ST_RESTART ##1 state_q == sr_pkg::ST_RUN);
	c_en_off: cover property (@(posedge hclk) disable iff (!hresetn)
		state_q == sr_pkg::ST_OFF ##1 state_q == sr_pkg::ST_BURST);
endmodule
`default_nettype wire

// [tb/sr_primary_model.sv]
// Primary-side switching model with settable conduction length
`timescale 1ns/100ps
`default_nettype none
module sr_primary_model (
	input wire logic hclk,
	input wire logic switching,
	input wire logic [5:0] cond_len,
	input wire logic gate_allow,
	output logic half_period_clk,
	output logic cond_a,
	output logic cond_b,
	output logic arm_a,
	output logic arm_b,
	output logic gate_on_a,
	output logic gate_on_b
);
	logic [5:0] cnt_q;
	logic side_q;
	logic cond;
	// 2 cycles high, 40 low per half period
	always_ff @(posedge hclk) begin
		if (!switching || cnt_q == 6'h29) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_q + 6'h01;
		end
	end
	always_ff @(posedge hclk) begin
		if (!switching) begin
			side_q <= 1'b0;
		end else if (cnt_q == 6'h29) begin
			side_q <= ~side_q;
		end
	end
	assign half_period_clk = switching && cnt_q < 6'h02;
	assign cond = switching && cnt_q >= 6'h02 && cnt_q < cond_len + 6'h02;
	assign cond_a = cond && !side_q;
	assign cond_b = cond && side_q;
	// Both drains high only while idle; bench idles well past 20 us
	assign arm_a = !switching || side_q;
	assign arm_b = !switching || !side_q;
	// Gate released where conduction ends
	assign gate_on_a = cond_a && gate_allow;
	assign gate_on_b = cond_b && gate_allow;
endmodule
`default_nettype wire

// [tb/sr_sleep_burst_controller_tb.sv]
// Self-checking bench for the sleep and burst controller
`timescale 1ns/100ps
`default_nettype none
module sr_sleep_burst_controller_tb;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans, en_level_code, exit_level_program_pin;
	logic [2:0] hsize;
	logic [5:0] cond_len;
	logic [6:0] ton_mask_pct, toff_point_pct;
	logic half_period_clk, cond_a, cond_b, arm_a, arm_b, gate_on_a, gate_on_b;
	logic supply_ok, en_below_off, en_above_on, switching, low_power;
	logic gate_drive_allow, en_source_run, program_pin_source_current;
	int n_fail, compares, n;
	localparam logic [6:0] EXIT_T [2][4] = '{'{7'h50, 7'h4B, 7'h41, 7'h3C},
		'{7'h4B, 7'h46, 7'h3C, 7'h37}};
	sr_sleep_burst_controller sr_sleep_burst_controller_inst (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .half_period_clk, .cond_a, .cond_b, .arm_a, .arm_b,
		.gate_on_a, .gate_on_b, .supply_ok, .en_below_off, .en_above_on,
		.en_level_code, .exit_level_program_pin, .gate_drive_allow, .low_power,
		.en_source_run, .program_pin_source_current, .ton_mask_pct,
		.toff_point_pct);
	sr_primary_model sr_primary_model_inst (.hclk, .switching, .cond_len,
		.gate_allow(gate_drive_allow), .half_period_clk, .cond_a, .cond_b,
		.arm_a, .arm_b, .gate_on_a, .gate_on_b);
	assign hready = hreadyout;
	always #5 hclk = ~hclk;
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic end_sim();
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		v = hrdata;
		chk("hresp", 1'b0, hresp);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		hwrite <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask
	// Inhibit bit overrides auto sleep; targets restored to reset values
	task automatic t_regs();
		wr(32'h00, 32'h00500F01);
		rd(32'h00, d);
		chk("ctrl", 32'h00500F01, d);
		rd(32'h04, d);
		chk("inhibit", 1'b0, d[3]);
		wr(32'h00, 32'h005F0A00);
		rd(32'h04, d);
		chk("auto", 1'b1, d[3]);
	endtask
	// Bounded wait on the gate level or, with lp set, on low power
	task automatic wt(input bit lp, input logic v, input int lim);
		n = 0;
		while ((lp ? low_power : gate_drive_allow) !== v && n < lim) begin
			@(negedge hclk);
			n++;
		end
		chk("wait", 1'b1, n < lim);
		@(posedge hclk);
	endtask
	task automatic t_start(input logic [1:0] en, input logic [1:0] pg);
		hresetn <= 1'b0;
		supply_ok <= 1'b0;
		switching <= 1'b0;
		en_level_code <= en;
		exit_level_program_pin <= pg;
		repeat (2) @(posedge hclk);
		chk("exit_level_program_pin_src", 1'b1, program_pin_source_current);
		chk("ton", sr_pkg::TON_INIT_PCT, ton_mask_pct);
		// Enable switch stays released here
		hresetn <= 1'b1;
		supply_ok <= 1'b1;
		wt(0, 1'b1, 20);
		chk("exit_level_program_pin_src", 1'b0, program_pin_source_current);
		chk("en_run", 1'b1, en_source_run);
		cond_len <= 6'h24;
		switching <= 1'b1;
		en_level_code <= ~en;
		exit_level_program_pin <= ~pg;
		repeat (200) @(posedge hclk);
		rd(32'h04, d);
		chk("status", {9'h0, EXIT_T[en == 2'h1][pg], 6'h0, pg, en, 2'h2, !en[1],
			3'h1}, d & 32'h007F03FF);
		rd(32'h08, d);
		chk("duty", 32'h0028005A, d & 32'hFFFF007F);
		rd(32'h40, d);
		chk("unmapped", 32'h0, d);
	endtask
	task automatic t_sleep();
		cond_len <= 6'h08;
		wt(0, 1'b0, 600 * 42);
		chk("confirm", 1'b1, n > 511 * 42);
		chk("sleep_lp", 1'b1, low_power);
		chk("soft", 1'b1, toff_point_pct <= sr_pkg::SOFT_FLOOR_PCT);
	endtask
	task automatic t_wake();
		cond_len <= 6'h24;
		wt(0, 1'b1, 40 * 42);
		chk("blank", 1'b1, n > 16 * 42);
		chk("wake", 1'b1, n < 24 * 42);
		chk("ton", sr_pkg::TON_INIT_PCT, ton_mask_pct);
		chk("toff", sr_pkg::TOFF_INIT_PCT, toff_point_pct);
	endtask
	task automatic t_burst();
		cond_len <= 6'h08;
		repeat (560 * 42) @(posedge hclk);
		chk("no_auto", 1'b1, gate_drive_allow);
		switching <= 1'b0;
		wt(1, 1'b1, 2100);
		chk("idle_span", 1'b1, n > 1990);
		chk("burst_gate", 1'b0, gate_drive_allow);
		repeat (500) @(posedge hclk);
		cond_len <= 6'h24;
		switching <= 1'b1;
		wt(0, 1'b1, 40 * 42);
		chk("restart", 1'b1, n > 24 * 42);
		chk("resume", 1'b1, n < 34 * 42);
	endtask
	task automatic t_enable();
		en_below_off <= 1'b1;
		wt(1, 1'b1, 10);
		chk("off_gate", 1'b0, gate_drive_allow);
		en_below_off <= 1'b0;
		en_above_on <= 1'b1;
		wt(0, 1'b1, 40 * 42);
	endtask
	initial begin
		hclk = 1'b0;
		n_fail = 0;
		compares = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		supply_ok = 1'b0;
		en_below_off = 1'b0;
		en_above_on = 1'b0;
		switching = 1'b0;
		cond_len = 6'h00;
		en_level_code = 2'h0;
		exit_level_program_pin = 2'h0;
		t_start(2'h0, 2'h2);
		t_regs();
		t_sleep();
		t_wake();
		t_start(2'h2, 2'h3);
		t_burst();
		t_enable();
		end_sim();
	end
	// Run needs about 55k cycles
	initial begin
		#900000;
		n_fail++;
		end_sim();
	end
endmodule
`default_nettype wire
